// [logic/cfts_consts.vh]
// Constants for the CAN filter and transmit scheduler block
// Operation
// - Bit rate zero selects automatic rate detection
// - Listen-only never acknowledges or disturbs frames; a frame already requested stays on tx_req_o until acked
// - Frame accepted if any channel accepts
// - Disabled channel accepts nothing
// - Route 1 store, 2 host, 3 both
// - Channel matches extended or standard identifiers
// - Identifier filter applies only when enabled
// - Pass when masked identifier equals masked filter
// - Thinning passes one in N per identifier
// - Thinning divisor up to 256; the 9-bit divisor field takes values up to 511 and is not clamped
// - Track 25 identifiers; others pass unthinned
// - Standard identifier is 11 bits, mask 7FF
// - Twenty transmit slots, active when configured
// - Always sent; route adds store/host copy
// - Periodic slot repeats every period ticks
// - Period zero sends exactly once
// - First send after delay; delay below period
// - Payload 0 to 8 bytes, length equals count
// - Extended select sends 29-bit identifier
// - Delay counted from power-up reset
`ifndef CFTS_CONSTS_VH
`define CFTS_CONSTS_VH
`define CFTS_CLK_HZ        50000000
`define CFTS_TICK_MS       10
`define CFTS_TICK_CYCLES   ((`CFTS_CLK_HZ / 1000) * `CFTS_TICK_MS)
`define CFTS_NUM_CH        4
`define CFTS_NUM_SLOT      20
`define CFTS_NUM_TRACK     25
`define CFTS_DIV_MAX       256
`define CFTS_STD_MASK      29'h0000_07FF
`define CFTS_EXT_MASK      29'h1FFF_FFFF
// Register byte addresses
`define CFTS_BUS_CFG       12'h000
`define CFTS_BIT_RATE      12'h004
`define CFTS_STATUS        12'h008
`define CFTS_PEND_MASK     12'h00C
`define CFTS_CH_BASE       6'h01
`define CFTS_SLOT_BASE     12'h100
// Bus configuration fields
`define CFTS_BUS_LISTEN    0
`define CFTS_BUS_CFG_RST   32'h0000_0000
`define CFTS_BIT_RATE_RST  32'h0000_0000
// Channel control fields
`define CFTS_CH_EN         0
`define CFTS_CH_EXT        1
`define CFTS_CH_FEN        2
`define CFTS_CH_RT_LO      4
`define CFTS_CH_DIV_LO     8
`define CFTS_CH_CTRL_RST   32'h0000_0100
// Slot control fields
`define CFTS_SL_CFG        0
`define CFTS_SL_EXT        1
`define CFTS_SL_RT_LO      2
`define CFTS_SL_LEN_LO     4
`endif

// [logic/cfts_can_filter_tx_scheduler.v]
// Acceptance filtering, thinning and periodic transmit scheduling
//
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`include "cfts_consts.vh"
module cfts_can_filter_tx_scheduler #(
   parameter integer TICK_CYCLES = `CFTS_TICK_CYCLES
) (
   input  wire        core_clk_i,
   input  wire        srst_i,
   input  wire        hsel_i,
   input  wire [31:0] haddr_i,
   input  wire [1:0]  htrans_i,
   input  wire        hwrite_i,
   input  wire [2:0]  hsize_i,
   input  wire [31:0] hwdata_i,
   input  wire        hready_i,
   output wire        hreadyout_o,
   output wire        hresp_o,
   output reg  [31:0] hrdata_o,
   output wire        autobaud_en_o,
   output wire        ack_enable_o,
   input  wire        rx_valid_i,
   input  wire        rx_ext_i,
   input  wire [28:0] rx_id_i,
   output reg         rx_to_store_o,
   output reg         rx_to_host_o,
   output reg         rx_out_ext_o,
   output reg  [28:0] rx_out_id_o,
   output reg         tx_req_o,
   output reg         tx_ext_o,
   output reg  [28:0] tx_id_o,
   output reg  [3:0]  tx_len_o,
   output reg  [63:0] tx_data_o,
   input  wire        tx_ack_i,
   output reg         tx_copy_store_o,
   output reg         tx_copy_host_o
);
   // Table sizes follow the feature set, not the bus map
   localparam integer NCH = `CFTS_NUM_CH;
   localparam integer NSL = `CFTS_NUM_SLOT;
   localparam integer NTR = `CFTS_NUM_TRACK;

   reg  [31:0] bus_cfg_q;
   reg  [31:0] bit_rate_q;
   reg  [31:0] ch_ctrl_q [0:NCH-1];
   reg  [31:0] ch_id_q   [0:NCH-1];
   reg  [31:0] ch_mask_q [0:NCH-1];
   reg  [31:0] sl_ctrl_q [0:NSL-1];
   reg  [31:0] sl_id_q   [0:NSL-1];
   reg  [31:0] sl_per_q  [0:NSL-1];
   reg  [31:0] sl_dly_q  [0:NSL-1];
   reg  [31:0] sl_dlo_q  [0:NSL-1];
   reg  [31:0] sl_dhi_q  [0:NSL-1];
   reg         wr_q;
   reg  [11:0] wa_q;
   wire [NSL-1:0] pend_q;
   reg         busy_q;
   reg  [4:0]  cur_q;

   wire listen = bus_cfg_q[`CFTS_BUS_LISTEN];
   assign autobaud_en_o = (bit_rate_q == 32'h0000_0000);
   assign ack_enable_o  = ~listen;
   assign hreadyout_o   = 1'b1;
   assign hresp_o       = 1'b0;
   // Status word: bit1 auto rate, bit2 listen-only, bit3 transmitter busy
   wire [31:0] status_w = {28'h000_0000, busy_q, listen, autobaud_en_o, 1'b0};

   // Register read decode
   function [31:0] rd_reg;
      input [31:0] a;
      reg   [11:0] so;
      reg   [4:0]  si;
      reg   [1:0]  ci;
      begin
         so = a[11:0] - `CFTS_SLOT_BASE;
         si = so[9:5];
         ci = a[5:4];
         rd_reg = 32'h0000_0000;
         if (a[31:12] == 20'h0_0000 && a[1:0] == 2'b00) begin
            if (a[11:0] == `CFTS_BUS_CFG)
               rd_reg = bus_cfg_q;
            else if (a[11:0] == `CFTS_BIT_RATE)
               rd_reg = bit_rate_q;
            else if (a[11:0] == `CFTS_STATUS)
               rd_reg = status_w;
            else if (a[11:0] == `CFTS_PEND_MASK)
               rd_reg = {12'h000, pend_q};
            else if (a[11:6] == `CFTS_CH_BASE) begin
               case (a[3:2])
                  2'd0: rd_reg = ch_ctrl_q[ci];
                  2'd1: rd_reg = ch_id_q[ci];
                  2'd2: rd_reg = ch_mask_q[ci];
                  default: rd_reg = 32'h0000_0000;
               endcase
            // Upper offset bits checked so high addresses do not alias slots
            end else if (a[11:0] >= `CFTS_SLOT_BASE && so[11:10] == 2'b00 && si < NSL) begin
               case (so[4:2])
                  3'd0: rd_reg = sl_ctrl_q[si];
                  3'd1: rd_reg = sl_id_q[si];
                  3'd2: rd_reg = sl_per_q[si];
                  3'd3: rd_reg = sl_dly_q[si];
                  3'd4: rd_reg = sl_dlo_q[si];
                  3'd5: rd_reg = sl_dhi_q[si];
                  default: rd_reg = 32'h0000_0000;
               endcase
            end
         end
      end
   endfunction

   // Zero-wait slave: read data prepared during the address phase
   wire take = hsel_i & htrans_i[1] & hready_i;
   wire [11:0] wso = wa_q - `CFTS_SLOT_BASE;
   wire [4:0]  wsi = wso[9:5];
   wire [1:0]  wci = wa_q[5:4];
   integer k;
   always @(posedge core_clk_i) begin
      if (srst_i) begin
         wr_q       <= 1'b0;
         wa_q       <= 12'h000;
         hrdata_o   <= 32'h0000_0000;
         bus_cfg_q  <= `CFTS_BUS_CFG_RST;
         bit_rate_q <= `CFTS_BIT_RATE_RST;
         for (k = 0; k < NCH; k = k + 1) begin
            ch_ctrl_q[k] <= `CFTS_CH_CTRL_RST;
            ch_id_q[k]   <= 32'h0000_0000;
            ch_mask_q[k] <= 32'h0000_0000;
         end
         for (k = 0; k < NSL; k = k + 1) begin
            sl_ctrl_q[k] <= 32'h0000_0000;
            sl_id_q[k]   <= 32'h0000_0000;
            sl_per_q[k]  <= 32'h0000_0000;
            sl_dly_q[k]  <= 32'h0000_0000;
            sl_dlo_q[k]  <= 32'h0000_0000;
            sl_dhi_q[k]  <= 32'h0000_0000;
         end
      end else begin
         // Only aligned words below 0x1000 are decoded
         if (hready_i) begin
            wr_q <= take & hwrite_i & (haddr_i[31:12] == 20'h0_0000)
                    & (haddr_i[1:0] == 2'b00);
            wa_q <= haddr_i[11:0];
         end
         // A read right behind a write to the same word sees the old value
         if (take & ~hwrite_i)
            hrdata_o <= rd_reg(haddr_i);
         // Write lands at the end of its data phase
         if (wr_q) begin
            if (wa_q == `CFTS_BUS_CFG)
               bus_cfg_q <= {31'h0000_0000, hwdata_i[`CFTS_BUS_LISTEN]};
            else if (wa_q == `CFTS_BIT_RATE)
               bit_rate_q <= hwdata_i;
            else if (wa_q[11:6] == `CFTS_CH_BASE) begin
               case (wa_q[3:2])
                  // Reserved control bits read back as zero
                  2'd0: ch_ctrl_q[wci] <= {15'h0000, hwdata_i[16:8], 2'b00,
                                           hwdata_i[5:4], 1'b0, hwdata_i[2:0]};
                  2'd1: ch_id_q[wci] <= {3'b000, hwdata_i[28:0]};
                  2'd2: ch_mask_q[wci] <= {3'b000, hwdata_i[28:0]};
                  default: ;
               endcase
            end else if (wa_q >= `CFTS_SLOT_BASE && wso[11:10] == 2'b00 && wsi < NSL) begin
               case (wso[4:2])
                  3'd0: sl_ctrl_q[wsi] <= {24'h00_0000,
                     (hwdata_i[7:4] > 4'd8) ? 4'd8 : hwdata_i[7:4],
                     hwdata_i[3:0]};
                  3'd1: sl_id_q[wsi] <= {3'b000, hwdata_i[28:0]};
                  3'd2: sl_per_q[wsi] <= hwdata_i;
                  3'd3: sl_dly_q[wsi] <= hwdata_i;
                  3'd4: sl_dlo_q[wsi] <= hwdata_i;
                  3'd5: sl_dhi_q[wsi] <= hwdata_i;
                  default: ;
               endcase
            end
         end
      end
   end

   // Acceptance channels
   wire [NCH-1:0] hit_st;
   wire [NCH-1:0] hit_ho;
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : g_ch
         reg  [28:0] ent_id_q  [0:NTR-1];
         reg  [8:0]  ent_cnt_q [0:NTR-1];
         reg  [NTR-1:0] ent_v_q;
         reg         fnd;
         reg  [4:0]  fnd_i;
         reg         fre;
         reg  [4:0]  fre_i;
         integer     j;
         integer     r;

         wire [31:0] cc   = ch_ctrl_q[g];
         wire [28:0] fm   = cc[`CFTS_CH_EXT] ? `CFTS_EXT_MASK
                                             : `CFTS_STD_MASK;
         wire [28:0] key  = rx_id_i & fm;
         wire        fmt  = (cc[`CFTS_CH_EXT] == rx_ext_i);
         wire        idok = ~cc[`CFTS_CH_FEN] |
            (((rx_id_i ^ ch_id_q[g][28:0]) & ch_mask_q[g][28:0] & fm)
             == 29'h0000_0000);
         wire        acc  = cc[`CFTS_CH_EN] & fmt & idok;
         // Divisor 0 treated as 1; field holds up to 511
         wire [8:0]  dv   = (cc[16:8] == 9'd0) ? 9'd1 : cc[16:8];
         wire [8:0]  c0   = ent_cnt_q[fnd_i];
         // Count wraps at the divisor; zero lets the next frame pass
         wire [8:0]  cnx  = (c0 + 9'd1 >= dv) ? 9'd0 : c0 + 9'd1;
         wire [8:0]  cnew = (dv == 9'd1) ? 9'd0 : 9'd1;
         wire        pass = acc & (~fnd | (c0 == 9'd0));

         always @* begin
            fnd   = 1'b0;
            fnd_i = 5'd0;
            fre   = 1'b0;
            fre_i = 5'd0;
            for (j = NTR - 1; j >= 0; j = j - 1) begin
               if (ent_v_q[j] && ent_id_q[j] == key) begin
                  fnd   = 1'b1;
                  fnd_i = j[4:0];
               end
               if (!ent_v_q[j]) begin
                  fre   = 1'b1;
                  fre_i = j[4:0];
               end
            end
         end

         always @(posedge core_clk_i) begin
            if (srst_i) begin
               ent_v_q <= {NTR{1'b0}};
               for (r = 0; r < NTR; r = r + 1) begin
                  ent_id_q[r]  <= 29'h0000_0000;
                  ent_cnt_q[r] <= 9'd0;
               end
            end else if (rx_valid_i & acc) begin
               if (fnd)
                  ent_cnt_q[fnd_i] <= cnx;
               else if (fre) begin
                  // First identifiers claim the table; later ones pass freely
                  ent_v_q[fre_i]   <= 1'b1;
                  ent_id_q[fre_i]  <= key;
                  ent_cnt_q[fre_i] <= cnew;
               end
            end
         end

         assign hit_st[g] = pass & (cc[`CFTS_CH_RT_LO+1:`CFTS_CH_RT_LO] == 2'd1
            | cc[`CFTS_CH_RT_LO+1:`CFTS_CH_RT_LO] == 2'd3);
         assign hit_ho[g] = pass & cc[`CFTS_CH_RT_LO+1];
      end
   endgenerate

   always @(posedge core_clk_i) begin
      if (srst_i) begin
         rx_to_store_o <= 1'b0;
         rx_to_host_o  <= 1'b0;
         rx_out_ext_o  <= 1'b0;
         rx_out_id_o   <= 29'h0000_0000;
      end else begin
         rx_to_store_o <= rx_valid_i & (|hit_st);
         rx_to_host_o  <= rx_valid_i & (|hit_ho);
         // Identifier copy follows every frame, routed or not
         if (rx_valid_i) begin
            rx_out_ext_o <= rx_ext_i;
            rx_out_id_o  <= rx_id_i;
         end
      end
   end

   // Shared tick and elapsed ticks since reset
   reg  [31:0] tdiv_q;
   reg  [31:0] elap_q;
   // Free-running divider; tick phase is set by reset release
   wire        tick = (tdiv_q == TICK_CYCLES - 1);
   always @(posedge core_clk_i) begin
      if (srst_i) begin
         tdiv_q <= 32'h0000_0000;
         elap_q <= 32'h0000_0000;
      end else begin
         tdiv_q <= tick ? 32'h0000_0000 : tdiv_q + 32'h0000_0001;
         if (tick)
            elap_q <= elap_q + 32'h0000_0001;
      end
   end

   // Transmit slots
   wire [31:0] elap_n = elap_q + 32'h0000_0001;
   reg  [4:0]  pick;
   integer     p;
   always @* begin
      pick = 5'd0;
      for (p = NSL - 1; p >= 0; p = p - 1)
         if (pend_q[p])
            pick = p[4:0];
   end

   // Listen-only holds frames pending instead of dropping them
   wire launch = ~busy_q & ~listen & (|pend_q);
   wire done   = busy_q & tx_ack_i;

   generate
      for (g = 0; g < NSL; g = g + 1) begin : g_sl
         reg         sent_q;
         reg  [31:0] next_q;
         reg         pnd_q;
         wire [31:0] base = sent_q ? next_q : sl_dly_q[g];
         wire        ackd = done & (cur_q == g);
         wire        live = sl_ctrl_q[g][`CFTS_SL_CFG];
         wire        once = (sl_per_q[g] == 32'h0000_0000);
         wire        due  = tick & live & ~(once & sent_q)
                            & (elap_n >= base) & ~ackd;
         assign pend_q[g] = pnd_q;

         always @(posedge core_clk_i) begin
            if (srst_i) begin
               sent_q <= 1'b0;
               next_q <= 32'h0000_0000;
               pnd_q  <= 1'b0;
            end else begin
               // Deconfiguring drops the request; an ack masks a due event in the same cycle, so the clear wins
               if (!live)
                  pnd_q <= 1'b0;
               else if (due)
                  pnd_q <= 1'b1;
               else if (ackd)
                  pnd_q <= 1'b0;
               if (ackd) begin
                  sent_q <= 1'b1;
                  // Next time follows the schedule, so missed periods catch up
                  next_q <= base + sl_per_q[g];
               end
            end
         end
      end
   endgenerate

   // Fields of the slot picked for launch
   wire [31:0] pk_ctrl = sl_ctrl_q[pick];
   wire        pk_ext  = pk_ctrl[`CFTS_SL_EXT];
   wire [28:0] pk_id   = sl_id_q[pick][28:0];

   always @(posedge core_clk_i) begin
      if (srst_i) begin
         busy_q          <= 1'b0;
         cur_q           <= 5'd0;
         tx_req_o        <= 1'b0;
         tx_ext_o        <= 1'b0;
         tx_id_o         <= 29'h0000_0000;
         tx_len_o        <= 4'd0;
         tx_data_o       <= 64'h0000_0000_0000_0000;
         tx_copy_store_o <= 1'b0;
         tx_copy_host_o  <= 1'b0;
      end else begin
         tx_copy_store_o <= 1'b0;
         tx_copy_host_o  <= 1'b0;
         if (launch) begin
            busy_q    <= 1'b1;
            cur_q     <= pick;
            tx_req_o  <= 1'b1;
            tx_ext_o  <= pk_ext;
            tx_id_o   <= pk_ext ? pk_id
                         : (pk_id & `CFTS_STD_MASK);
            tx_len_o  <= pk_ctrl[`CFTS_SL_LEN_LO+3:`CFTS_SL_LEN_LO];
            tx_data_o <= {sl_dhi_q[pick], sl_dlo_q[pick]};
         end else if (done) begin
            busy_q          <= 1'b0;
            tx_req_o        <= 1'b0;
            tx_copy_store_o <= sl_ctrl_q[cur_q][`CFTS_SL_RT_LO];
            tx_copy_host_o  <= sl_ctrl_q[cur_q][`CFTS_SL_RT_LO+1];
         end
      end
   end
endmodule // cfts_can_filter_tx_scheduler

// [bench/cfts_chk.sv]
// Port-level property checker for the filter and transmit scheduler
module cfts_chk (
   input wire logic        core_clk_i,
   input wire logic        srst_i,
   input wire logic        hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0]  htrans_i,
   input wire logic        hwrite_i,
   input wire logic [31:0] hwdata_i,
   input wire logic        hready_i,
   input wire logic        autobaud_en_o,
   input wire logic        ack_enable_o,
   input wire logic        rx_valid_i,
   input wire logic        rx_ext_i,
   input wire logic [28:0] rx_id_i,
   input wire logic        rx_to_store_o,
   input wire logic        rx_to_host_o,
   input wire logic        rx_out_ext_o,
   input wire logic [28:0] rx_out_id_o,
   input wire logic        tx_req_o,
   input wire logic [28:0] tx_id_o,
   input wire logic [3:0]  tx_len_o,
   input wire logic [63:0] tx_data_o,
   input wire logic        tx_ack_i,
   input wire logic        tx_copy_store_o,
   input wire logic        tx_copy_host_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (srst_i);
   wire wr_a = hsel_i && htrans_i[1] && hready_i && hwrite_i;
   chk_auto_rate: assert property (wr_a && haddr_i == 32'h0000_0004 ##1 hwdata_i == 32'h0000_0000
      |=> autobaud_en_o) else $error("zero rate did not enable detection");
   chk_fixed_rate: assert property (wr_a && haddr_i == 32'h0000_0004 ##1 hwdata_i != 32'h0000_0000
      |=> !autobaud_en_o) else $error("fixed rate left detection on");
   chk_listen_ack: assert property (wr_a && haddr_i == 32'h0000_0000 ##1 hwdata_i[0]
      |=> !ack_enable_o) else $error("acknowledge still enabled while silent");
   chk_listen_quiet: assert property (!ack_enable_o && !tx_req_o |=> !tx_req_o)
      else $error("frame launched while silent");
   chk_tx_hold: assert property (tx_req_o && !tx_ack_i |=> tx_req_o && $stable(tx_id_o)
      && $stable(tx_len_o) && $stable(tx_data_o)) else $error("frame changed before ack");
   chk_tx_done: assert property (tx_req_o && tx_ack_i |=> !tx_req_o)
      else $error("request held after ack");
   chk_copy_cause: assert property (tx_copy_store_o || tx_copy_host_o |->
      $past(tx_req_o && tx_ack_i)) else $error("copy pulse without a sent frame");
   chk_rx_cause: assert property (rx_to_store_o || rx_to_host_o |-> $past(rx_valid_i))
      else $error("route pulse without a frame");
   chk_len_limit: assert property (tx_req_o |-> tx_len_o <= 4'h8)
      else $error("length code above eight");
   chk_rx_copy: assert property (rx_valid_i |=> rx_out_id_o == $past(rx_id_i)
      && rx_out_ext_o == $past(rx_ext_i)) else $error("received frame copy wrong");
endmodule // cfts_chk

bind cfts_can_filter_tx_scheduler cfts_chk u_chk (.core_clk_i, .srst_i, .hsel_i, .haddr_i,
   .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .autobaud_en_o, .ack_enable_o, .rx_valid_i,
   .rx_ext_i, .rx_id_i, .rx_to_store_o, .rx_to_host_o, .rx_out_ext_o, .rx_out_id_o, .tx_req_o,
   .tx_id_o, .tx_len_o, .tx_data_o, .tx_ack_i, .tx_copy_store_o, .tx_copy_host_o);

// [bench/cfts_can_node.sv]
// Other bus nodes: acknowledge each launched frame, alternately prompt and slow
module cfts_can_node (
   input  wire logic core_clk_i,
   input  wire logic srst_i,
   input  wire logic tx_req_i,
   output logic      tx_ack_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int   wait_q;
   logic slow_q;
   always @(posedge core_clk_i) begin
      if (srst_i) begin
         tx_ack_o <= 1'b0;
         wait_q <= 0;
         slow_q <= 1'b0;
      end else if (tx_ack_o) begin
         tx_ack_o <= 1'b0;
         wait_q <= 0;
         slow_q <= !slow_q;
      end else if (tx_req_i) begin
         // Ack only while a frame is offered
         wait_q <= wait_q + 1;
         tx_ack_o <= wait_q >= (slow_q ? 3 : 0);
      end
   end
endmodule // cfts_can_node

// [bench/tb_can_filter_tx_scheduler.sv]
// Self-checking bench for the filter and transmit scheduler
module tb_can_filter_tx_scheduler;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 20;
   logic        core_clk_i = 0, srst_i = 1, hsel_i = 1, hwrite_i = 0;
   logic        rx_valid_i = 0, rx_ext_i = 0, rx_to_store_o, rx_to_host_o, rx_out_ext_o;
   logic [1:0]  htrans_i = 0;
   logic [2:0]  hsize_i = 3'h2;
   logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o;
   logic [28:0] rx_id_i = 0, rx_out_id_o, tx_id_o;
   logic        hreadyout_o, hresp_o, autobaud_en_o, ack_enable_o, tx_req_o, tx_ext_o;
   logic        tx_ack_i, tx_copy_store_o, tx_copy_host_o, rq_d = 0, cv = 0, lsn = 0;
   logic [3:0]  tx_len_o;
   logic [63:0] tx_data_o, dat[3];
   logic [28:0] cid[4] = '{29'h7D0, 0, 0, 29'h100}, cmk[4] = '{29'h7FE, 0, 0, 29'h7FF};
   logic [28:0] sidv[3] = '{29'h1, 29'h1ABC_DEF0, 29'h7FF}, tk[4][$];
   logic [1:0]  rq[$], ce, x;
   int cen[4] = '{1, 1, 0, 1}, cex[4] = '{0, 1, 0, 0}, cfe[4] = '{1, 0, 0, 1};
   int crt[4] = '{1, 2, 3, 3}, cdv[4] = '{1, 3, 256, 2}, tn[4][$];
   int sl[3] = '{0, 1, 19}, per[3] = '{0, 5, 7}, dly[3] = '{9, 4, 4}, len[3] = '{1, 8, 0};
   int srt[3] = '{1, 2, 0}, sex[3] = '{0, 1, 0}, eq[$], cr, cyc = 0, nlate = 0;
   int seed = 32'h0000_171c, checked = 0, miscompares = 0;
   wire hready_i = hreadyout_o;

   cfts_can_filter_tx_scheduler #(.TICK_CYCLES(TK)) u_cfts_can_filter_tx_scheduler (
      .core_clk_i, .srst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
      .hready_i, .hreadyout_o, .hresp_o, .hrdata_o, .autobaud_en_o, .ack_enable_o,
      .rx_valid_i, .rx_ext_i, .rx_id_i, .rx_to_store_o, .rx_to_host_o, .rx_out_ext_o,
      .rx_out_id_o, .tx_req_o, .tx_ext_o, .tx_id_o, .tx_len_o, .tx_data_o, .tx_ack_i,
      .tx_copy_store_o, .tx_copy_host_o);
   cfts_can_node u_cfts_can_node (.core_clk_i, .srst_i, .tx_req_i(tx_req_o), .tx_ack_o(tx_ack_i));

   initial begin
      forever #10 core_clk_i = !core_clk_i;
   end

   task ck(input logic [63:0] g, input logic [63:0] e, input string m);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask

   task wt;
      do @(posedge core_clk_i); while (hready_i !== 1'b1);
   endtask

   // Address phase held until hready, then data phase
   task wr(input logic [31:0] a, input logic [31:0] d);
      htrans_i <= 2'h2;
      haddr_i <= a;
      hwrite_i <= 1'b1;
      wt();
      htrans_i <= 2'h0;
      hwdata_i <= d;
      wt();
   endtask

   task rd(input logic [31:0] a, input logic [31:0] e);
      htrans_i <= 2'h2;
      haddr_i <= a;
      hwrite_i <= 1'b0;
      wt();
      htrans_i <= 2'h0;
      wt();
      ck(hresp_o, 0, "bus response");
      ck(hrdata_o, e, "read data");
   endtask

   task model(input logic e, input logic [28:0] id, output logic [1:0] r);
      int k;
      logic p;
      r = 0;
      for (int c = 0; c < 4; c++) begin
         if (cen[c] && cex[c] == e && (!cfe[c] || (id & cmk[c]) == (cid[c] & cmk[c]))) begin
            p = 1;
            k = -1;
            for (int n = 0; n < tk[c].size(); n++) if (tk[c][n] == id) k = n;
            if (k >= 0) begin
               tn[c][k]++;
               p = tn[c][k] % cdv[c] == 0;
            end else if (tk[c].size() < 25) begin
               tk[c].push_back(id);
               tn[c].push_back(0);
            end
            if (p) r = r | 2'(crt[c]);
         end
      end
   endtask

   task till(input int n);
      while (cyc < n) @(posedge core_clk_i);
   endtask

   task give_verdict;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   always @(posedge core_clk_i) begin
      if (!srst_i) begin
         cyc <= cyc + 1;
         if (cv) ck({tx_copy_host_o, tx_copy_store_o}, ce, "copy pulses");
         cv <= tx_req_o && tx_ack_i && cr >= 0;
         if (tx_req_o && !rq_d) begin
            if (lsn) ck(1, 0, "send while silent");
            else if (eq.size() == 0) begin
               nlate++;
               cr = -1;
            end else begin
               cr = eq.pop_front();
               ck((cyc - 1) / TK, cr / 4, "launch tick");
               cr = cr % 4;
               ck({tx_ext_o, tx_id_o}, {1'(sex[cr]), sidv[cr]}, "frame id");
               ck({tx_len_o, tx_data_o}, {4'(len[cr]), dat[cr]}, "frame body");
               ce <= 2'(srt[cr]);
            end
         end
         rq_d <= tx_req_o;
      end
   end

   initial begin
      #50us;
      miscompares++;
      give_verdict();
   end

   initial begin
      logic v, e;
      logic [28:0] id;
      int k;
      dat = '{64'h0000_0000_0000_0001, {$random(seed), $random(seed)}, 64'h0};
      // Slots listed in slot order, so equal ticks queue lowest first
      for (int t = 1; t < 30; t++)
         for (int j = 0; j < 3; j++)
            if (t == dly[j] || (per[j] > 0 && t > dly[j] && (t - dly[j]) % per[j] == 0))
               eq.push_back(t * 4 + j);
      repeat (6) @(posedge core_clk_i);
      srst_i <= 1'b0;
      @(posedge core_clk_i);
      for (int j = 0; j < 3; j++) begin
         k = 32'h0000_0100 + 32 * sl[j];
         wr(k + 4, {3'h0, sidv[j]});
         wr(k + 8, per[j]);
         wr(k + 12, dly[j]);
         wr(k + 16, dat[j][31:0]);
         wr(k + 20, dat[j][63:32]);
         wr(k, {24'h0, 4'(len[j]), 2'(srt[j]), 1'(sex[j]), 1'b1});
      end
      rd(32'h0000_0040, 32'h0000_0100);
      rd(32'h0000_0004, 32'h0);
      ck(autobaud_en_o, 1, "auto rate at reset");
      wr(32'h0000_0004, 32'h0007_A120);
      rd(32'h0000_0004, 32'h0007_A120);
      ck(autobaud_en_o, 0, "fixed rate");
      wr(32'h0000_0004, 32'h0);
      rd(32'h0000_0ffc, 32'h0);
      rd(32'h0000_1000, 32'h0);
      wr(32'h0000_0900, 32'h0);
      rd(32'h0000_0900, 32'h0);
      rd(32'h0000_0100, 32'h0000_0015);
      rd(32'h0000_0008, 32'h0000_0002);
      ck(autobaud_en_o, 1, "auto rate again");
      for (int c = 0; c < 4; c++) begin
         k = 32'h0000_0040 + 16 * c;
         wr(k, {15'h0, 9'(cdv[c]), 2'h0, 2'(crt[c]), 1'b0, 1'(cfe[c]), 1'(cex[c]), 1'(cen[c])});
         wr(k + 4, {3'h0, cid[c]});
         wr(k + 8, {3'h0, cmk[c]});
      end
      rd(32'h0000_0060, {15'h0, 9'h100, 8'h30});
      for (int i = 0; i < 201; i++) begin
         v = i < 200 && ($random(seed) & 3) != 0;
         e = $random(seed);
         k = $random(seed) & 3;
         id = e ? 29'h100_0000 | ($random(seed) & 31) : k == 0 ? 29'h7D0 : k == 1 ? 29'h7D1
            : k == 2 ? 29'h100 : $random(seed) & 29'h7FF;
         x = 0;
         if (v) model(e, id, x);
         rq.push_back(x);
         rx_valid_i <= v;
         rx_ext_i <= e;
         rx_id_i <= v ? id : 29'($random(seed));
         @(posedge core_clk_i);
         if (rq.size() == 2) ck({rx_to_host_o, rx_to_store_o}, rq.pop_front(), "rx route");
      end
      till(30 * TK - 12);
      wr(32'h0000_0000, 32'h1);
      lsn = 1;
      rd(32'h0000_0000, 32'h1);
      ck(ack_enable_o, 0, "silent acknowledge");
      ck(eq.size(), 0, "schedule done");
      till(40 * TK + 10);
      lsn = 0;
      wr(32'h0000_0000, 32'h0);
      till(43 * TK);
      // Two held frames, then one catch-up period each for slots 1 and 19
      ck(nlate, 4, "held frames released");
      give_verdict();
   end
endmodule // tb_can_filter_tx_scheduler
